// ===== gtmc_consts.svh
// register offsets, field positions, reset values and widths of the timer
// assumes byte addressing on a 32-bit avalon-mm slave port
`ifndef GTMC_CONSTS_SVH
`define GTMC_CONSTS_SVH

`define GTMC_ADDR_W        8
`define GTMC_OFS_CTRL_ONE  8'h00
`define GTMC_OFS_CTRL_ZERO 8'h04
`define GTMC_OFS_COUNT     8'h08
`define GTMC_OFS_RELOAD    8'h0c
`define GTMC_OFS_PWM       8'h10
`define GTMC_OFS_CAPTURE   8'h14
`define GTMC_OFS_INT_STS   8'h18
`define GTMC_OFS_INT_CLR   8'h1c
`define GTMC_OFS_INT_EN    8'h20
`define GTMC_OFS_PIN_STS   8'h24

`define GTMC_RST_CTRL_ONE  8'h00
`define GTMC_RST_CTRL_ZERO 8'h00
`define GTMC_RST_COUNT     16'h0000
`define GTMC_RST_RELOAD    16'hffff
`define GTMC_RST_PWM       16'h0000
`define GTMC_COUNT_START   16'h0001

`define GTMC_INT_W         3
`define GTMC_INT_RELOAD    0
`define GTMC_INT_CAPTURE   1
`define GTMC_INT_GATE      2

`define GTMC_PRE_W         7
`define GTMC_PRE_ONES      7'h7f
`define GTMC_DB_W          8
`define GTMC_DB_ONE        8'h01

`endif

// ===== gtmc_pkg.sv
// types of the general timer: operating modes and control register layouts
// used together with gtmc_consts.svh
package gtmc_pkg;

  typedef enum logic [3:0] {
    GTMC_ONESHOT = 4'b0000,
    GTMC_CONT    = 4'b0001,
    GTMC_COUNTER = 4'b0010,
    GTMC_PWM1    = 4'b0011,
    GTMC_CAPT    = 4'b0100,
    GTMC_COMPARE = 4'b0101,
    GTMC_GATED   = 4'b0110,
    GTMC_CAPCMP  = 4'b0111,
    GTMC_PWM2    = 4'b1000,
    GTMC_CAPRST  = 4'b1001,
    GTMC_CMPCNT  = 4'b1010,
    GTMC_TRIG    = 4'b1011
  } gtmc_mode_e;

  typedef struct packed {
    logic       timer_enable_bit;
    logic       output_polarity_bit;
    logic [2:0] clock_divide_select;
    logic [2:0] operating_mode_select;
  } gtmc_ctrl_one_s;

  typedef struct packed {
    logic       mode_top;
    logic [2:0] rsvd_hi;
    logic [2:0] complement_delay_select;
    logic       rsvd_lo;
  } gtmc_ctrl_zero_s;

endpackage

// ===== gtmc_timer.sv
// general timer: prescaler, 16-bit counter, twelve operating modes, avalon slave
// assumes tin_i is asynchronous to sys_clk_i; one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
`include "gtmc_consts.svh"

// Overview of operation
// - disabled timer drives output at polarity level
// - one-shot: output inverted one cycle after reload
// - most other modes toggle output on reload
// - counter mode counts polarity-selected input edge
// - capture modes capture count on selected edge
// - single pwm: match sets inverse, reload restores
// - gated: count while active level, interrupt inactive edge
// - capture/compare: first edge starts, later edges capture
// - dual pwm: complement opposite of output, both low during delay
// - dual pwm: delay only rising edges (deadband)
// - triggered one-shot starts on polarity-selected edge
// - prescaler divides by two to field power
// - prescaler cleared while timer disabled
// - mode top bit from other control register
// - decode codes 0000..1011 as twelve modes
// - hardware clears enable when timer stops
// - complement delay: zero or 2..128 cycles
module gtmc_timer (
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic [`GTMC_ADDR_W-1:0]   avs_address_i,
  input  wire logic                      avs_read_i,
  input  wire logic                      avs_write_i,
  input  wire logic [31:0]               avs_writedata_i,
  input  wire logic [3:0]                avs_byteenable_i,
  output var  logic [31:0]               avs_readdata_o,
  output var  logic                      avs_waitrequest_o,
  input  wire logic                      tin_i,
  output var  logic                      tout_o,
  output var  logic                      tout_n_o,
  output var  logic                      irq_o
);

  gtmc_pkg::gtmc_ctrl_one_s  ctrl_one;
  gtmc_pkg::gtmc_ctrl_zero_s ctrl_zero;
  gtmc_pkg::gtmc_mode_e      mode;
  logic [15:0]               count;
  logic [15:0]               reload;
  logic [15:0]               pwm_val;
  logic [15:0]               capture;
  logic [`GTMC_INT_W-1:0]    int_sts;
  logic [`GTMC_INT_W-1:0]    int_en;
  logic [2:0]                tin_sync;
  logic                      tin_lvl;
  logic                      tin_prev;
  logic [`GTMC_PRE_W-1:0]    pre_cnt;
  logic [`GTMC_PRE_W-1:0]    pre_mask;
  logic                      armed;
  logic                      out_level;
  logic                      pulse;
  logic                      db_prev;
  logic [`GTMC_DB_W-1:0]     db_cnt;
  logic [`GTMC_DB_W-1:0]     db_len;
  logic                      db_ok;
  logic                      en;
  logic                      pol;
  logic                      tick;
  logic                      rise;
  logic                      fall;
  logic                      act_edge;
  logic                      inact_edge;
  logic                      adv;
  logic                      reload_ev;
  logic                      match_ev;
  logic                      capt_ev;
  logic                      gate_ev;
  logic                      hw_stop;
  logic                      restart;
  logic                      is_pwm;
  logic                      next_tout;
  logic                      next_tout_n;
  logic                      wr_fire;
  logic                      rd_take;
  logic [31:0]               rd_mux;

  assign en       = ctrl_one.timer_enable_bit;
  assign pol      = ctrl_one.output_polarity_bit;
  assign mode     = gtmc_pkg::gtmc_mode_e'({ctrl_zero.mode_top,
                                            ctrl_one.operating_mode_select});
  assign is_pwm   = (mode == gtmc_pkg::GTMC_PWM1) || (mode == gtmc_pkg::GTMC_PWM2);
  assign wr_fire  = avs_write_i && !avs_waitrequest_o;
  assign rd_take  = avs_read_i && avs_waitrequest_o;

  // three-stage synchroniser; a level counts once stages two and three agree
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      tin_sync <= 3'h0;
    else
      tin_sync <= {tin_sync[1:0], tin_i};
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      tin_lvl  <= 1'b0;
      tin_prev <= 1'b0;
    end
    else
    begin
      if (tin_sync[1] == tin_sync[2])
        tin_lvl <= tin_sync[2];
      tin_prev <= tin_lvl;
    end
  end

  assign rise       = tin_lvl && !tin_prev;
  assign fall       = !tin_lvl && tin_prev;
  assign act_edge   = pol ? fall : rise;
  assign inact_edge = pol ? rise : fall;

  // prescaler restarts from zero on every enable, so the first tick is a full period
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      pre_cnt <= '0;
    else if (!en)
      pre_cnt <= '0;
    else
      pre_cnt <= pre_cnt + 1'b1;
  end

  assign pre_mask = ~(`GTMC_PRE_ONES << ctrl_one.clock_divide_select);
  assign tick     = en && ((pre_cnt & pre_mask) == pre_mask);

  always_comb
  begin
    adv = 1'b0;
    case (mode)
      gtmc_pkg::GTMC_COUNTER: adv = en && act_edge;
      gtmc_pkg::GTMC_GATED:   adv = tick && (tin_lvl != pol);
      gtmc_pkg::GTMC_CAPCMP:  adv = tick && armed;
      gtmc_pkg::GTMC_TRIG:    adv = tick && armed;
      gtmc_pkg::GTMC_ONESHOT,
      gtmc_pkg::GTMC_CONT,
      gtmc_pkg::GTMC_PWM1,
      gtmc_pkg::GTMC_CAPT,
      gtmc_pkg::GTMC_COMPARE,
      gtmc_pkg::GTMC_PWM2,
      gtmc_pkg::GTMC_CAPRST,
      gtmc_pkg::GTMC_CMPCNT:  adv = tick;
      default:                adv = 1'b0;
    endcase
  end

  assign reload_ev = adv && (count >= reload);
  assign match_ev  = adv && is_pwm && (count == pwm_val);
  assign capt_ev   = en && act_edge &&
                     ((mode == gtmc_pkg::GTMC_CAPT) || (mode == gtmc_pkg::GTMC_CAPRST) ||
                      (mode == gtmc_pkg::GTMC_CMPCNT) ||
                      ((mode == gtmc_pkg::GTMC_CAPCMP) && armed));
  assign restart   = capt_ev &&
                     ((mode == gtmc_pkg::GTMC_CAPRST) || (mode == gtmc_pkg::GTMC_CAPCMP));
  assign gate_ev   = en && (mode == gtmc_pkg::GTMC_GATED) && inact_edge;
  assign hw_stop   = reload_ev &&
                     ((mode == gtmc_pkg::GTMC_ONESHOT) || (mode == gtmc_pkg::GTMC_TRIG));

  // start gate for capture/compare and triggered one-shot
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      armed <= 1'b0;
    else if (!en)
      armed <= 1'b0;
    else if (act_edge && ((mode == gtmc_pkg::GTMC_CAPCMP) || (mode == gtmc_pkg::GTMC_TRIG)))
      armed <= 1'b1;
  end

  // counter and capture; a software write to the count wins over counting
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      count   <= `GTMC_RST_COUNT;
      capture <= `GTMC_RST_COUNT;
    end
    else
    begin
      if (capt_ev)
        capture <= count;
      if (wr_fire && (avs_address_i == `GTMC_OFS_COUNT))
        count <= merge16(count, avs_writedata_i[15:0], avs_byteenable_i[1:0]);
      else if (restart || reload_ev)
        count <= `GTMC_COUNT_START;
      else if (adv)
        count <= count + 1'b1;
    end
  end

  // internal output level before the one-shot pulse and deadband
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      out_level <= 1'b0;
    else if (!en)
      out_level <= pol;
    else if (is_pwm)
    begin
      if (reload_ev)
        out_level <= pol;
      else if (match_ev)
        out_level <= !pol;
    end
    else if (reload_ev && (mode != gtmc_pkg::GTMC_ONESHOT))
      out_level <= !out_level;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      pulse <= 1'b0;
    else
      pulse <= reload_ev && (mode == gtmc_pkg::GTMC_ONESHOT);
  end

  // deadband: only the rising side waits, falling sides act at once
  assign db_len = (ctrl_zero.complement_delay_select == 3'h0) ? '0 :
                  (`GTMC_DB_ONE << ctrl_zero.complement_delay_select);
  assign db_ok  = (out_level != db_prev) ? (db_len == '0) : (db_cnt == '0);

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      db_prev <= 1'b0;
      db_cnt  <= '0;
    end
    else
    begin
      db_prev <= out_level;
      if (out_level != db_prev)
        db_cnt <= (db_len == '0) ? '0 : db_len - 1'b1;
      else if (db_cnt != '0)
        db_cnt <= db_cnt - 1'b1;
    end
  end

  always_comb
  begin
    next_tout   = out_level;
    next_tout_n = !out_level;
    if (pulse)
    begin
      next_tout   = !pol;
      next_tout_n = pol;
    end
    else if (!en)
    begin
      next_tout   = pol;
      next_tout_n = !pol;
    end
    else if (mode == gtmc_pkg::GTMC_PWM2)
    begin
      next_tout   = out_level && db_ok;
      next_tout_n = !out_level && db_ok;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      tout_o   <= 1'b0;
      tout_n_o <= 1'b1;
    end
    else
    begin
      tout_o   <= next_tout;
      tout_n_o <= next_tout_n;
    end
  end

  // control registers; a software write wins over the hardware stop
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_one  <= gtmc_pkg::gtmc_ctrl_one_s'(`GTMC_RST_CTRL_ONE);
      ctrl_zero <= gtmc_pkg::gtmc_ctrl_zero_s'(`GTMC_RST_CTRL_ZERO);
    end
    else
    begin
      if (wr_fire && (avs_address_i == `GTMC_OFS_CTRL_ONE) && avs_byteenable_i[0])
        ctrl_one <= gtmc_pkg::gtmc_ctrl_one_s'(avs_writedata_i[7:0]);
      else if (hw_stop)
        ctrl_one.timer_enable_bit <= 1'b0;
      if (wr_fire && (avs_address_i == `GTMC_OFS_CTRL_ZERO) && avs_byteenable_i[0])
      begin
        ctrl_zero.mode_top                <= avs_writedata_i[7];
        ctrl_zero.complement_delay_select <= avs_writedata_i[3:1];
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      reload  <= `GTMC_RST_RELOAD;
      pwm_val <= `GTMC_RST_PWM;
    end
    else if (wr_fire)
    begin
      if (avs_address_i == `GTMC_OFS_RELOAD)
        reload <= merge16(reload, avs_writedata_i[15:0], avs_byteenable_i[1:0]);
      if (avs_address_i == `GTMC_OFS_PWM)
        pwm_val <= merge16(pwm_val, avs_writedata_i[15:0], avs_byteenable_i[1:0]);
    end
  end

  // sticky events: a set in the clearing cycle survives
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      int_sts <= '0;
      int_en  <= '0;
      irq_o   <= 1'b0;
    end
    else
    begin
      if (wr_fire && (avs_address_i == `GTMC_OFS_INT_CLR) && avs_byteenable_i[0])
        int_sts <= (int_sts & ~avs_writedata_i[`GTMC_INT_W-1:0]) |
                   {gate_ev, capt_ev, reload_ev};
      else
        int_sts <= int_sts | {gate_ev, capt_ev, reload_ev};
      if (wr_fire && (avs_address_i == `GTMC_OFS_INT_EN) && avs_byteenable_i[0])
        int_en <= avs_writedata_i[`GTMC_INT_W-1:0];
      irq_o <= |(int_sts & int_en);
    end
  end

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (avs_address_i)
      `GTMC_OFS_CTRL_ONE:  rd_mux[7:0]  = ctrl_one;
      `GTMC_OFS_CTRL_ZERO: rd_mux[7:0]  = {ctrl_zero.mode_top, 3'h0,
                                          ctrl_zero.complement_delay_select, 1'b0};
      `GTMC_OFS_COUNT:     rd_mux[15:0] = count;
      `GTMC_OFS_RELOAD:    rd_mux[15:0] = reload;
      `GTMC_OFS_PWM:       rd_mux[15:0] = pwm_val;
      `GTMC_OFS_CAPTURE:   rd_mux[15:0] = capture;
      `GTMC_OFS_INT_STS:   rd_mux[`GTMC_INT_W-1:0] = int_sts;
      `GTMC_OFS_INT_EN:    rd_mux[`GTMC_INT_W-1:0] = int_en;
      `GTMC_OFS_PIN_STS:   rd_mux[2:0]  = {tin_lvl, tout_n_o, tout_o};
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  // fixed one wait state keeps the read mux off the bus timing path
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
    end
    else
    begin
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
      if (rd_take)
        avs_readdata_o <= rd_mux;
    end
  end

  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0]  be);
    merge16 = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

endmodule
`default_nettype wire

// ===== gtmc_checker.sv
// checker of the general timer: bus handshake and output levels per mode
// sees only the timer's ports; keeps shadows of the writes it observes
`timescale 1ns/1ps
`default_nettype none
`include "gtmc_consts.svh"
module gtmc_checker (
  input  wire logic                    sys_clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic [`GTMC_ADDR_W-1:0] avs_address_i,
  input  wire logic                    avs_read_i,
  input  wire logic                    avs_write_i,
  input  wire logic [31:0]             avs_writedata_i,
  input  wire logic [31:0]             avs_readdata_o,
  input  wire logic                    avs_waitrequest_o,
  input  wire logic                    tout_o,
  input  wire logic                    tout_n_o,
  input  wire logic                    irq_o
);
  logic [7:0] sh_c;
  logic [7:0] sh_z;
  logic [2:0] sh_ie;
  logic [1:0] quiet;
  logic       t1;
  logic       t2;
  logic       wok;
  logic [3:0] mode;
  assign wok  = avs_write_i && !avs_waitrequest_o;
  assign mode = {sh_z[7], sh_c[2:0]};
  // shadow misses the hardware enable clear, so only a 0 is trusted
  always_ff @(posedge sys_clk_i)
  begin
    t1 <= tout_o;
    t2 <= t1;
    if (!rst_n_i)
    begin
      sh_c  <= 8'h00;
      sh_z  <= 8'h00;
      sh_ie <= 3'h0;
      quiet <= 2'h0;
    end
    else
    begin
      quiet <= wok ? 2'h0 : (quiet == 2'h3 ? quiet : quiet + 2'h1);
      if (wok && avs_address_i == `GTMC_OFS_CTRL_ONE) sh_c <= avs_writedata_i[7:0];
      if (wok && avs_address_i == `GTMC_OFS_CTRL_ZERO) sh_z <= avs_writedata_i[7:0];
      if (wok && avs_address_i == `GTMC_OFS_INT_EN) sh_ie <= avs_writedata_i[2:0];
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  reset_quiet_a: assert property ($rose(rst_n_i) |-> avs_waitrequest_o && !irq_o && tout_n_o)
    else $error("outputs not at rest after reset");
  wait_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("no answer one cycle after request");
  wait_once_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low two cycles");
  unmapped_zero_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i > 8'h24
    |-> avs_readdata_o == 32'h0000_0000) else $error("unmapped read not zero");
  idle_polarity_a: assert property (quiet == 2'h3 && !sh_c[7] |-> tout_o == sh_c[6])
    else $error("disabled output differs from polarity");
  oneshot_pulse_a: assert property (mode == gtmc_pkg::GTMC_ONESHOT && sh_c[7]
    && quiet == 2'h3 && tout_o != t1 && t1 == t2 |=> tout_o == t2)
    else $error("one-shot pulse not one cycle");
  dual_gap_a: assert property (mode == gtmc_pkg::GTMC_PWM2 && sh_c[7] && quiet == 2'h3
    |-> !(tout_o && tout_n_o)) else $error("both dual outputs high");
  dual_compl_a: assert property (mode == gtmc_pkg::GTMC_PWM2 && sh_c[7] && quiet == 2'h3
    && sh_z[3:1] == 3'h0 |-> tout_n_o != tout_o) else $error("complement not opposite");
  irq_masked_a: assert property (quiet == 2'h3 && sh_ie == 3'h0 |-> !irq_o)
    else $error("interrupt with all enables off");
  cover property (mode == gtmc_pkg::GTMC_ONESHOT && tout_o != t1);
  cover property (mode == gtmc_pkg::GTMC_PWM2 && tout_n_o && quiet == 2'h3);
  cover property (irq_o);
endmodule
`default_nettype wire

// ===== gtmc_pin_model.sv
// source standing on the timer input pin
// follows the level the bench asks for, changing only at a clock edge
`timescale 1ns/1ps
`default_nettype none
module gtmc_pin_model (
  input  wire logic clk_i,
  input  wire logic lvl_i,
  output var  logic tin_o
);
  // a pushed-pull driver: no release state to model
  initial tin_o = 1'b0;
  always @(posedge clk_i) tin_o <= lvl_i;
endmodule
`default_nettype wire

// ===== test_gtmc_timer.sv
// self-checking bench of the general timer: bus, pins, modes, interrupt
// drives the avalon port itself; the pin model feeds the timer input
`timescale 1ns/1ps
`default_nettype none
`include "gtmc_consts.svh"
module test_gtmc_timer;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic        rreq = 1'b0;
  logic        wreq = 1'b0;
  logic        lvl = 1'b0;
  logic [31:0] rdat;
  logic [31:0] v;
  logic        wtr;
  logic        tin;
  logic        tout;
  logic        toutn;
  logic        irq;
  logic        pol;
  logic [3:0]  cm [4] = '{4'h4, 4'h9, 4'ha, 4'h7}; // only defined codes
  logic [2:0]  dsel;
  int          n_fail = 0;
  int          comparisons = 0;
  int          p;
  int          k;
  int          p0;
  int          d0;
  int          rl;
  always #5 clk = ~clk;
  gtmc_timer i_gtmc_timer (.sys_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(adr),
    .avs_read_i(rreq), .avs_write_i(wreq), .avs_writedata_i(wdat),
    .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wtr),
    .tin_i(tin), .tout_o(tout), .tout_n_o(toutn), .irq_o(irq));
  gtmc_pin_model i_gtmc_pin_model (.clk_i(clk), .lvl_i(lvl), .tin_o(tin));
  task automatic conclude();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic hung(input int c);
    if (c >= 3000)
    begin
      n_fail++;
      conclude();
    end
  endtask
  // request held until waitrequest low is seen at a rising edge
  task automatic bus(input logic r, input logic [7:0] a, input logic [31:0] d);
    int c;
    adr  <= a;
    wdat <= d;
    rreq <= r;
    wreq <= !r;
    for (c = 0; c < 3000; c++)
    begin
      @(posedge clk);
      if (wtr === 1'b0)
        break;
    end
    hung(c);
    v = rdat;
    rreq <= 1'b0;
    wreq <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b1, a, 32'h0000_0000);
  endtask
  // synchroniser plus edge stage settle well inside eight cycles
  task automatic pin(input logic b);
    lvl <= b;
    repeat (8) @(posedge clk);
  endtask
  task automatic irqchk(input logic e);
    @(negedge clk);
    chk("irq", 32'(irq), 32'(e));
    @(posedge clk);
  endtask
  // k: cycles to the first output change, p: cycles to the next one
  task automatic per();
    logic t;
    @(negedge clk);
    t = tout;
    for (k = 0; tout === t && k < 3000; k++) @(negedge clk);
    hung(k);
    t = tout;
    for (p = 0; tout === t && p < 3000; p++) @(negedge clk);
    hung(p);
    @(posedge clk);
  endtask
  // always restarts from disabled with the count at one
  task automatic cfg(input logic pl, input logic [2:0] s, input logic [3:0] m,
                     input logic [2:0] dl, input logic [31:0] r);
    wr(`GTMC_OFS_CTRL_ONE, 32'h0000_0000);
    wr(`GTMC_OFS_CTRL_ZERO, {24'h0, m[3], 3'h0, dl, 1'b0});
    wr(`GTMC_OFS_COUNT, 32'h0000_0001);
    wr(`GTMC_OFS_RELOAD, r);
    wr(`GTMC_OFS_CTRL_ONE, {24'h0, 1'b1, pl, s, m[2:0]});
  endtask
  // high time of tout: polarity level lasts to the match, its inverse to reload
  function automatic int hi_len(input logic pl, input logic [2:0] sel);
    int d;
    d = (sel == 3'h0) ? 0 : (1 << sel);
    return (pl ? 16 : 48 - 16) - d;
  endfunction
  function automatic logic [31:0] hits(input logic [3:0] m, input int n);
    return (n == 1 || (n == 0 && m == 4'h7)) ? 32'h0 : 32'h1;
  endfunction
  initial
  begin
    void'($urandom(63537));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`GTMC_OFS_CTRL_ONE);
    chk("ctrl_one", v, 32'h0000_0000);
    rd(`GTMC_OFS_RELOAD);
    chk("reload", v, 32'h0000_ffff);
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40);
    chk("unmapped", v, 32'h0000_0000);
    for (int i = 0; i < 2; i++)
    begin
      wr(`GTMC_OFS_CTRL_ONE, {25'h0, i[0], 6'h00});
      rd(`GTMC_OFS_PIN_STS);
      chk("idle", 32'(v[0]), 32'(i[0]));
    end
    rl = 2 + $urandom % 4;
    for (int s = 0; s < 8; s++)
    begin
      cfg(1'b0, s[2:0], s[0] ? 4'h5 : 4'h1, 3'h0, 32'(rl));
      per();
      if (s == 0)
      begin
        p0 = p;
        d0 = k - p;
      end
      chk("period", 32'(p), 32'(p0 << s));
      chk("phase", 32'(k - p), 32'(d0));
    end
    cfg(1'b0, 3'h0, 4'h0, 3'h0, 32'h0000_0003);
    per();
    chk("pulse", 32'(p), 32'h1);
    rd(`GTMC_OFS_CTRL_ONE);
    chk("stop", 32'(v[7]), 32'h0);
    for (int i = 0; i < 2; i++)
    begin
      pin(1'b0);
      cfg(i[0], 3'h0, 4'h2, 3'h0, 32'h0000_ffff);
      pin(1'b1);
      pin(1'b0);
      pin(1'b1);
      rd(`GTMC_OFS_COUNT);
      chk("edges", v, i[0] ? 32'h2 : 32'h3);
    end
    foreach (cm[j])
    begin
      pol = 1'($urandom);
      pin(pol);
      cfg(pol, 3'h0, cm[j], 3'h0, 32'h0000_ffff);
      for (int n = 0; n < 3; n++)
      begin
        wr(`GTMC_OFS_INT_CLR, 32'h0000_0007);
        pin(pol ^ !n[0]);
        rd(`GTMC_OFS_INT_STS);
        chk("capture", 32'(v[1]), hits(cm[j], n));
      end
    end
    pol = 1'($urandom);
    pin(pol);
    cfg(pol, 3'h0, 4'h6, 3'h0, 32'h0000_ffff);
    wr(`GTMC_OFS_INT_EN, 32'h0000_0004);
    wr(`GTMC_OFS_INT_CLR, 32'h0000_0007);
    rd(`GTMC_OFS_COUNT);
    p = v;
    pin(pol);
    rd(`GTMC_OFS_COUNT);
    chk("gate held", v, 32'(p));
    pin(!pol);
    pin(pol);
    rd(`GTMC_OFS_COUNT);
    chk("gate ran", 32'(v > 32'(p)), 32'h1);
    rd(`GTMC_OFS_INT_STS);
    chk("gate edge", 32'(v[2]), 32'h1);
    irqchk(1'b1);
    wr(`GTMC_OFS_INT_EN, 32'h0000_0000);
    irqchk(1'b0);
    wr(`GTMC_OFS_INT_EN, 32'h0000_0004);
    irqchk(1'b1);
    wr(`GTMC_OFS_INT_CLR, 32'h0000_0004);
    irqchk(1'b0);
    pol = 1'($urandom);
    pin(pol);
    cfg(pol, 3'h0, 4'hb, 3'h0, 32'h0000_ffff);
    pin(pol);
    rd(`GTMC_OFS_COUNT);
    chk("armed", v, 32'h1);
    pin(!pol);
    rd(`GTMC_OFS_COUNT);
    chk("fired", 32'(v > 32'h1), 32'h1);
    // deadband up to 8 only: a longer one could swallow the high phase
    wr(`GTMC_OFS_PWM, 32'h0000_0010);
    for (int i = 0; i < 3; i++)
    begin
      pol = 1'($urandom);
      dsel = (i == 1) ? 3'($urandom % 3 + 1) : 3'h0;
      cfg(pol, 3'h0, (i == 2) ? 4'h3 : 4'h8, dsel, 32'h0000_0030);
      repeat (2)
      begin
        per();
        chk("high time", 32'(p), 32'(hi_len(pol, dsel)));
      end
    end
    conclude();
  end
endmodule
bind gtmc_timer gtmc_checker i_gtmc_checker (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .tout_o(tout_o), .tout_n_o(tout_n_o),
  .irq_o(irq_o));
`default_nettype wire
